//--- rtl/ufb_map.vh
// Register offsets, field positions, reset values and timing counts of the serial frame block.
`ifndef UFB_MAP_VH
`define UFB_MAP_VH

// ************************************************************
// Register offsets on the register port.
// ************************************************************
`define UFB_ADDR_DATA 3'h0
`define UFB_ADDR_STATUS_A 3'h1
`define UFB_ADDR_CTRL_B 3'h2
`define UFB_ADDR_FORMAT 3'h3
`define UFB_ADDR_BAUD_HI 3'h4
`define UFB_ADDR_BAUD_LO 3'h5

// ************************************************************
// Field positions in link_status_a.
// ************************************************************
`define UFB_A_RXC 7
`define UFB_A_TXC 6
`define UFB_A_UDRE 5
`define UFB_A_FE 4
`define UFB_A_PE 2
`define UFB_A_DBL 1

// ************************************************************
// Field positions in frame_ctrl_b.
// ************************************************************
`define UFB_B_RXEN 4
`define UFB_B_TXEN 3
`define UFB_B_SIZE2 2
`define UFB_B_RX9 1
`define UFB_B_TX9 0

// ************************************************************
// Field positions in frame_format_ctrl.
// ************************************************************
`define UFB_C_SYNC 6
`define UFB_C_PAR_HI 5
`define UFB_C_PAR_LO 4
`define UFB_C_STOP 3
`define UFB_C_SIZE_HI 2
`define UFB_C_SIZE_LO 1
`define UFB_C_POL 0

// ************************************************************
// Reset values.
// ************************************************************
`define UFB_STATUS_RST 8'h20
`define UFB_CTRLB_RST 8'h00
`define UFB_FORMAT_RST 8'h06
`define UFB_BAUD_RST 12'h000

// ************************************************************
// Oversampling counts per bit, as last count and half-bit start.
// ************************************************************
`define UFB_SPB_NORM_MAX 4'hF
`define UFB_SPB_DBL_MAX 4'h7
`define UFB_HALF_NORM 4'h7
`define UFB_HALF_DBL 4'h3

`endif

//--- rtl/ufb_baud.v
// Baud-rate prescaler that gives one tick every divisor-plus-one clocks.
`include "ufb_map.vh"

module ufb_baud (
  // Clock and reset.
  input wire clock,
  input wire rst_n,
  // Divisor and reload strobe.
  input wire [11:0] divisor,
  input wire reload,
  // One-cycle tick.
  output reg tick
);

  reg [11:0] count;

  // Down counter; a reload restarts the period at once, so a frame in flight is disturbed.
  always @(posedge clock) begin
    if (!rst_n) begin
      count <= `UFB_BAUD_RST;
      tick <= 1'b0;
    end else if (reload) begin
      count <= divisor; // [RULE15] [RULE17]
      tick <= 1'b0;
    end else if (count == 12'h000) begin
      count <= divisor; // [RULE20]
      tick <= 1'b1;
    end else begin
      count <= count - 12'h001;
      tick <= 1'b0;
    end
  end

endmodule

//--- rtl/ufb_top.v
// Serial frame block with frame format, parity, stop bits and baud divisor configuration.
//
// Chosen here: strobed register access and the placing of the registers.
`include "ufb_map.vh"

//  Contract
// RULE1 - Three-bit size code picks 5, 6, 7, 8 or 9 data bits for both directions.
// RULE2 - With nine bits, the received ninth bit reads from frame_ctrl_b.
// RULE3 - Software reads the ninth received bit before the data window.
// RULE4 - With nine bits, the stored transmit ninth bit goes out as data bit eight.
// RULE5 - Software sets the transmit ninth bit before writing the data window.
// RULE6 - Mode select zero is asynchronous, one is synchronous.
// RULE7 - Parity code: 00 off, 01 reserved, 10 even, 11 odd.
// RULE8 - With parity on, the transmitter appends parity of the data bits.
// RULE9 - With parity on, the receiver checks parity and flags a mismatch.
// RULE10 - Stop select zero sends one stop bit, one sends two.
// RULE11 - The receiver ignores the stop count selection.
// RULE12 - Sync polarity zero: transmit on rising, sample on falling; one swaps.
// RULE13 - Software keeps clock polarity zero in asynchronous mode.
// RULE14 - Baud divisor is twelve bits, four high and eight low.
// RULE15 - Writing the low divisor byte reloads the prescaler at once.
// RULE16 - Software writes zeros to the four reserved high divisor bits.
// RULE17 - Changing the divisor corrupts a frame in flight; change only when idle.
// RULE18 - Parity error flag belongs to the buffered character received with a mismatch.
// RULE19 - Double speed divides oversampling from sixteen to eight, async only.
// RULE20 - Async bit rate is clock over sixteen or eight times divisor plus one.
// RULE21 - Software avoids reserved size and parity codes.
module ufb_top (
  // Clock and reset.
  input wire CLOCK,
  input wire RST_N,
  // Register port.
  input wire [2:0] ADDR,
  input wire [7:0] WR_DATA,
  input wire WR_EN,
  input wire RD_EN,
  output reg [7:0] RD_DATA,
  // Serial lines.
  input wire RXD,
  output reg TXD,
  output reg XCK_O,
  output reg XCK_OE
);

  // ************************************************************
  // State codes and helper functions.
  // ************************************************************
  localparam RX_IDLE = 2'b01;
  localparam RX_BUSY = 2'b10;
  localparam TX_IDLE = 2'b01;
  localparam TX_BUSY = 2'b10;
  // Reset words are kept whole so that each field can be picked out by position.
  localparam [7:0] FORMAT_RST = `UFB_FORMAT_RST;
  localparam [7:0] STATUS_RST = `UFB_STATUS_RST;

  // Data bits per frame; reserved codes fall back to eight.
  function [3:0] char_bits;
    input [2:0] code;
    begin
      case (code)
        3'b000: char_bits = 4'h5; // [RULE1]
        3'b001: char_bits = 4'h6; // [RULE1]
        3'b010: char_bits = 4'h7; // [RULE1]
        3'b011: char_bits = 4'h8; // [RULE1]
        3'b111: char_bits = 4'h9; // [RULE1]
        default: char_bits = 4'h8; // [RULE21]
      endcase
    end
  endfunction

  // Mask of the live data bits for a given width.
  function [8:0] data_mask;
    input [3:0] n;
    begin
      data_mask = ~(9'h1FF << n);
    end
  endfunction

  // Parity over the live data bits; the odd select inverts it.
  function parity_of;
    input [8:0] data;
    input [3:0] n;
    input odd;
    begin
      parity_of = (^(data & data_mask(n))) ^ odd;
    end
  endfunction

  // Whole outgoing frame, first bit in bit zero, idle ones above.
  function [12:0] tx_frame;
    input [8:0] data;
    input [3:0] n;
    input pen;
    input podd;
    integer i;
    begin
      tx_frame = 13'h1FFF;
      tx_frame[0] = 1'b0;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < n) begin
          tx_frame[i + 1] = data[i];
        end
      end
      if (pen) begin
        tx_frame[n + 1] = parity_of(data, n, podd); // [RULE8]
      end
    end
  endfunction

  // ************************************************************
  // Register state.
  // ************************************************************
  reg [7:0] rx_buf;
  reg rx_ninth_bit;
  reg rxc;
  reg fe;
  reg parity_err_flag;
  reg txc;
  reg udre;
  reg double_speed;
  reg rx_en;
  reg tx_en;
  reg char_size_top_bit;
  reg tx_ninth_bit;
  reg sync_mode_select;
  reg [1:0] parity_mode_sel;
  reg stop_count_sel;
  reg [1:0] char_size_low_bits;
  reg clk_edge_polarity;
  reg [3:0] baud_hi;
  reg [7:0] baud_lo;
  reg [7:0] tx_buf;
  reg tx_buf9;

  // Receive and transmit engines.
  reg [1:0] rx_state;
  reg [3:0] rx_cnt;
  reg [3:0] rx_idx;
  reg [11:0] rx_bits;
  reg rx_done;
  reg [1:0] tx_state;
  reg [3:0] tx_cnt;
  reg [12:0] tx_sh;
  reg [3:0] tx_left;
  reg tx_end;

  wire tick;

  // ************************************************************
  // Decode and derived settings.
  // ************************************************************
  wire wr_data_win = WR_EN && (ADDR == `UFB_ADDR_DATA);
  wire rd_data_win = RD_EN && (ADDR == `UFB_ADDR_DATA);
  wire wr_status = WR_EN && (ADDR == `UFB_ADDR_STATUS_A);
  wire wr_ctrl_b = WR_EN && (ADDR == `UFB_ADDR_CTRL_B);
  wire wr_format = WR_EN && (ADDR == `UFB_ADDR_FORMAT);
  wire wr_baud_hi = WR_EN && (ADDR == `UFB_ADDR_BAUD_HI);
  wire wr_baud_lo = WR_EN && (ADDR == `UFB_ADDR_BAUD_LO);

  wire [3:0] nbits = char_bits({char_size_top_bit, char_size_low_bits}); // [RULE1]
  wire par_en = parity_mode_sel[1]; // [RULE7]
  wire par_odd = parity_mode_sel[0]; // [RULE7]
  wire is_sync = sync_mode_select; // [RULE6]
  // Double speed only shortens the asynchronous bit; sync mode ignores it.
  wire [3:0] spb_max = (double_speed && !is_sync) ? `UFB_SPB_DBL_MAX : `UFB_SPB_NORM_MAX; // [RULE19]
  wire [3:0] half_bit = (double_speed && !is_sync) ? `UFB_HALF_DBL : `UFB_HALF_NORM; // [RULE19]
  wire [11:0] baud_divisor = {baud_hi, baud_lo}; // [RULE14]

  // Sync clock edges; polarity picks which edge shifts and which samples.
  wire xck_rise = is_sync && tick && !XCK_O;
  wire xck_fall = is_sync && tick && XCK_O;
  wire tx_edge = clk_edge_polarity ? xck_fall : xck_rise; // [RULE12]
  wire rx_edge = clk_edge_polarity ? xck_rise : xck_fall; // [RULE12]
  wire tx_step = is_sync ? tx_edge : (tick && (tx_cnt == spb_max));
  wire rx_sample = is_sync ? rx_edge : (tick && (rx_cnt == spb_max));

  // Receiver frame length ignores the stop count: one stop bit is checked.
  wire [3:0] rx_last = nbits + {3'b000, par_en} + 4'h1; // [RULE11]
  wire [8:0] rx_data = rx_bits[9:1] & data_mask(nbits);
  wire rx_par_bit = rx_bits[nbits + 4'h1];
  wire rx_stop_bit = rx_bits[rx_last];
  wire [3:0] tx_len = nbits + {3'b000, par_en} + {3'b000, stop_count_sel} + 4'h2; // [RULE10]

  // ************************************************************
  // Baud prescaler.
  // ************************************************************
  ufb_baud u_baud (
    .clock(CLOCK),
    .rst_n(RST_N),
    .divisor(baud_divisor),
    .reload(wr_baud_lo),
    .tick(tick)
  );

  // ************************************************************
  // Configuration registers.
  // ************************************************************
  // Plain configuration storage written from the register port.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      double_speed <= 1'b0;
      {rx_en, tx_en, char_size_top_bit, tx_ninth_bit} <= 4'h0;
      {sync_mode_select, parity_mode_sel, stop_count_sel} <= FORMAT_RST[6:3];
      char_size_low_bits <= FORMAT_RST[2:1];
      clk_edge_polarity <= 1'b0;
      baud_hi <= 4'h0;
      baud_lo <= 8'h00;
    end else begin
      if (wr_status) begin
        double_speed <= WR_DATA[`UFB_A_DBL];
      end
      if (wr_ctrl_b) begin
        rx_en <= WR_DATA[`UFB_B_RXEN];
        tx_en <= WR_DATA[`UFB_B_TXEN];
        char_size_top_bit <= WR_DATA[`UFB_B_SIZE2];
        tx_ninth_bit <= WR_DATA[`UFB_B_TX9];
      end
      if (wr_format) begin
        sync_mode_select <= WR_DATA[`UFB_C_SYNC];
        parity_mode_sel <= WR_DATA[`UFB_C_PAR_HI:`UFB_C_PAR_LO];
        stop_count_sel <= WR_DATA[`UFB_C_STOP];
        char_size_low_bits <= WR_DATA[`UFB_C_SIZE_HI:`UFB_C_SIZE_LO];
        clk_edge_polarity <= WR_DATA[`UFB_C_POL];
      end
      // Only the low nibble is stored; the reserved bits are not kept.
      if (wr_baud_hi) begin
        baud_hi <= WR_DATA[3:0]; // [RULE14] [RULE16]
      end
      if (wr_baud_lo) begin
        baud_lo <= WR_DATA; // [RULE14]
      end
    end
  end

  // ************************************************************
  // Read port.
  // ************************************************************
  // Read data stand only in the cycle after the strobe; unmapped offsets read zero.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      RD_DATA <= 8'h00;
    end else if (RD_EN) begin
      case (ADDR)
        `UFB_ADDR_DATA: RD_DATA <= rx_buf;
        `UFB_ADDR_STATUS_A: RD_DATA <= {rxc, txc, udre, fe, 1'b0, parity_err_flag, double_speed, 1'b0};
        `UFB_ADDR_CTRL_B: RD_DATA <= {3'b000, rx_en, tx_en, char_size_top_bit, rx_ninth_bit, tx_ninth_bit}; // [RULE2]
        `UFB_ADDR_FORMAT: RD_DATA <= {1'b0, sync_mode_select, parity_mode_sel, stop_count_sel,
                                      char_size_low_bits, clk_edge_polarity};
        `UFB_ADDR_BAUD_HI: RD_DATA <= {4'h0, baud_hi};
        `UFB_ADDR_BAUD_LO: RD_DATA <= baud_lo;
        default: RD_DATA <= 8'h00;
      endcase
    end else begin
      RD_DATA <= 8'h00;
    end
  end

  // ************************************************************
  // Sync clock pin.
  // ************************************************************
  // The pin toggles on every prescaler tick in sync mode and rests low otherwise.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      XCK_O <= 1'b0;
      XCK_OE <= 1'b0;
    end else begin
      XCK_OE <= is_sync; // [RULE6]
      if (!is_sync) begin
        XCK_O <= 1'b0; // [RULE13]
      end else if (tick) begin
        XCK_O <= ~XCK_O;
      end
    end
  end

  // ************************************************************
  // Receiver.
  // ************************************************************
  // Async frames are sampled mid-bit from a half-bit start offset; sync frames on the sample edge.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 4'h0;
      rx_idx <= 4'h0;
      rx_bits <= 12'hFFF;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        rx_cnt <= (rx_cnt == spb_max) ? 4'h0 : rx_cnt + 4'h1;
      end
      case (rx_state)
        RX_IDLE: begin
          if (rx_en && !RXD && is_sync && rx_edge) begin
            rx_state <= RX_BUSY;
            rx_bits <= 12'hFFE;
            rx_idx <= 4'h1;
          end else if (rx_en && !RXD && !is_sync) begin
            rx_state <= RX_BUSY;
            rx_bits <= 12'hFFF;
            rx_idx <= 4'h0;
            rx_cnt <= half_bit; // [RULE19]
          end
        end
        RX_BUSY: begin
          if (!rx_en) begin
            rx_state <= RX_IDLE;
          end else if (rx_sample) begin
            rx_bits[rx_idx] <= RXD;
            if (rx_idx == 4'h0 && RXD) begin
              // A start bit that is high again at mid-bit was a glitch.
              rx_state <= RX_IDLE;
            end else if (rx_idx == rx_last) begin
              rx_state <= RX_IDLE; // [RULE11]
              rx_done <= 1'b1;
            end else begin
              rx_idx <= rx_idx + 4'h1;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer and its flags; a new character wins over a read that clears the flag.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      rx_buf <= 8'h00;
      rx_ninth_bit <= 1'b0;
      rxc <= 1'b0;
      fe <= 1'b0;
      parity_err_flag <= 1'b0;
    end else if (!rx_en) begin
      rxc <= 1'b0;
      fe <= 1'b0;
      parity_err_flag <= 1'b0;
    end else begin
      rxc <= rx_done | (rxc & ~rd_data_win); // [RULE3]
      if (rx_done) begin
        rx_buf <= rx_data[7:0];
        rx_ninth_bit <= rx_data[8]; // [RULE2]
        fe <= ~rx_stop_bit;
        parity_err_flag <= par_en && (rx_par_bit != parity_of(rx_data, nbits, par_odd)); // [RULE9] [RULE18]
      end else if (rd_data_win) begin
        // The error flags describe the buffered character, so they go once it is read.
        fe <= 1'b0;
        parity_err_flag <= 1'b0; // [RULE18]
      end
    end
  end

  // ************************************************************
  // Transmitter.
  // ************************************************************
  // Buffer handshake: a data write is taken only while the buffer is empty.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      tx_buf <= 8'h00;
      tx_buf9 <= 1'b0;
      udre <= STATUS_RST[`UFB_A_UDRE];
      txc <= 1'b0;
    end else begin
      if (wr_data_win && udre) begin
        tx_buf <= WR_DATA;
        tx_buf9 <= tx_ninth_bit; // [RULE4] [RULE5]
        udre <= 1'b0;
      end else if (!udre && tx_en && tx_state == TX_IDLE) begin
        udre <= 1'b1;
      end
      txc <= (tx_end && udre) | (txc & ~(wr_status && WR_DATA[`UFB_A_TXC]));
    end
  end

  // Shift engine; disabling the transmitter lets the current frame finish.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 4'h0;
      tx_sh <= 13'h1FFF;
      tx_left <= 4'h0;
      tx_end <= 1'b0;
      TXD <= 1'b1;
    end else begin
      tx_end <= 1'b0;
      if (tick) begin
        tx_cnt <= (tx_cnt == spb_max) ? 4'h0 : tx_cnt + 4'h1;
      end
      case (tx_state)
        TX_IDLE: begin
          TXD <= 1'b1;
          if (!udre && tx_en) begin
            tx_sh <= tx_frame({tx_buf9, tx_buf}, nbits, par_en, par_odd); // [RULE4] [RULE8]
            tx_left <= tx_len; // [RULE10]
            tx_state <= TX_BUSY;
          end
        end
        TX_BUSY: begin
          if (tx_step) begin
            if (tx_left == 4'h0) begin
              tx_state <= TX_IDLE;
              tx_end <= 1'b1;
            end else begin
              TXD <= tx_sh[0]; // [RULE12]
              tx_sh <= {1'b1, tx_sh[12:1]};
              tx_left <= tx_left - 4'h1;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

endmodule

//--- verif/ufb_checker.sv
// Checker for register read-back, serial bit timing and clock pin behaviour.
`include "ufb_map.vh"
module ufb_checker (
  // Clock and reset.
  input logic CLOCK,
  input logic RST_N,
  // Register port.
  input logic [2:0] ADDR,
  input logic [7:0] WR_DATA,
  input logic WR_EN,
  input logic RD_EN,
  input logic [7:0] RD_DATA,
  // Serial lines.
  input logic RXD,
  input logic TXD,
  input logic XCK_O,
  input logic XCK_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fmt;
  logic [7:0] ctl;
  logic [11:0] div;
  logic dbl;
  logic [3:0] low_run;
  // Shadow copies of the writable fields, so read-back can be judged.
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      fmt <= 8'h06;
      ctl <= 8'h00;
      div <= 12'h000;
      dbl <= 1'b0;
    end else if (WR_EN) begin
      if (ADDR == `UFB_ADDR_FORMAT) fmt <= WR_DATA;
      if (ADDR == `UFB_ADDR_CTRL_B) ctl <= WR_DATA;
      if (ADDR == `UFB_ADDR_BAUD_HI) div[11:8] <= WR_DATA[3:0];
      if (ADDR == `UFB_ADDR_BAUD_LO) div[7:0] <= WR_DATA;
      if (ADDR == `UFB_ADDR_STATUS_A) dbl <= WR_DATA[1];
    end
  end
  // Low stretches exist only inside frames, so their length shows the bit time.
  always @(posedge CLOCK) begin
    if (!RST_N || TXD) low_run <= 4'h0;
    else low_run <= low_run + 4'h1;
  end
  // ****************************************
  // Properties.
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_read(logic [2:0] a);
    RD_EN && ADDR == a;
  endsequence
  sequence s_async_held;
    !fmt[6] [*3];
  endsequence
  property p_fmt_read;
    s_read(`UFB_ADDR_FORMAT) |=> RD_DATA == {1'b0, fmt[6:0]};
  endproperty
  a_fmt_read: assert property (p_fmt_read) else $error("format read-back wrong");
  property p_div_read;
    RD_EN && (ADDR == `UFB_ADDR_BAUD_HI || ADDR == `UFB_ADDR_BAUD_LO) |=>
      RD_DATA == ($past(ADDR) == `UFB_ADDR_BAUD_HI ? {4'h0, div[11:8]} : div[7:0]);
  endproperty
  a_div_read: assert property (p_div_read) else $error("divisor read-back wrong");
  property p_ctl_read;
    s_read(`UFB_ADDR_CTRL_B) |=> {RD_DATA[7:2], RD_DATA[0]} == {3'b000, ctl[4:2], ctl[0]};
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control B read-back wrong");
  property p_rx9_zero;
    s_read(`UFB_ADDR_CTRL_B) ##0 !(ctl[2] && fmt[2:1] == 2'b11) |=> !RD_DATA[1];
  endproperty
  a_rx9_zero: assert property (p_rx9_zero) else $error("ninth bit set outside 9-bit mode");
  property p_async_pin;
    s_async_held |-> !XCK_O && !XCK_OE;
  endproperty
  a_async_pin: assert property (p_async_pin) else $error("clock pin active in async mode");
  property p_sync_oe;
    fmt[6] |=> XCK_OE;
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("clock pin not driven in sync mode");
  property p_sync_tick;
    (fmt[6] && div == 12'h000) [*3] |-> $changed(XCK_O);
  endproperty
  a_sync_tick: assert property (p_sync_tick) else $error("clock pin missed a tick");
  property p_sync_edge;
    fmt[6] && $past(fmt[6]) && $changed(TXD) |-> $changed(XCK_O) && XCK_O == !fmt[0];
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("data changed on wrong clock edge");
  property p_bit_norm;
    !fmt[6] && !dbl && div == 12'h000 && $rose(TXD) |-> low_run == 4'h0;
  endproperty
  a_bit_norm: assert property (p_bit_norm) else $error("bit time not sixteen clocks");
  property p_bit_dbl;
    !fmt[6] && dbl && div == 12'h000 && $rose(TXD) |-> low_run[2:0] == 3'h0;
  endproperty
  a_bit_dbl: assert property (p_bit_dbl) else $error("bit time not eight clocks");
endmodule

bind ufb_top ufb_checker u_checker (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
  .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .RXD(RXD), .TXD(TXD), .XCK_O(XCK_O), .XCK_OE(XCK_OE));

//--- verif/ufb_peer.sv
// Model of the remote serial transceiver on the transmit and receive lines.
module ufb_peer (
  // Clock.
  input wire logic clock,
  // Serial lines.
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // The line idles high between frames.
  initial rxd = 1'b1;
  // Send a frame LSB first with a single stop bit, whatever the far end selects.
  task automatic send(input logic [15:0] v, input int nb, input int bt);
    for (int i = 0; i < nb; i++) begin
      rxd <= v[i];
      repeat (bt) @(posedge clock);
    end
    rxd <= 1'b1;
  endtask
  // Wait for a start edge, then sample every bit at its middle.
  task automatic grab(input int nb, input int bt, output logic [15:0] v, output bit ok);
    int n;
    v = '0;
    ok = 1'b0;
    for (n = 0; n < 4000 && txd !== 1'b0; n++) @(posedge clock);
    if (txd === 1'b0) begin
      ok = 1'b1;
      repeat (bt / 2) @(posedge clock);
      for (int i = 0; i < nb; i++) begin
        v[i] = txd;
        repeat (bt) @(posedge clock);
      end
    end
  endtask
endmodule

//--- verif/tb_top.sv
// Self-checking bench: registers, frames in both directions, speeds and sync clock.
`include "ufb_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and the frame case table.
  // ****************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic rxd;
  logic txd;
  logic xck_o;
  logic xck_oe;
  logic [7:0] stat_w = 8'h00;
  int failures = 0;
  int checked = 0;
  // Reserved size and parity codes are never programmed.
  logic [2:0] sz [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int nbits [5] = '{5, 6, 7, 8, 9};
  logic [1:0] pm [5] = '{2'h2, 2'h3, 2'h0, 2'h3, 2'h2};
  bit sb [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  bit bd [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [8:0] dv [5] = '{9'h0B5, 9'h02A, 9'h07F, 9'h0C3, 9'h1A5};
  // The clock runs at 250 MHz.
  always #2 clock = ~clock;
  ufb_top u_dut (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
    .RD_EN(rd_en), .RD_DATA(rd_data), .RXD(rxd), .TXD(txd), .XCK_O(xck_o), .XCK_OE(xck_oe));
  ufb_peer u_peer (.clock(clock), .txd(txd), .rxd(rxd));
  // ****************************************
  // Bus tasks and comparisons.
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A clock edge passes after each strobe, so no strobe is driven twice at one edge.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(posedge clock);
    chk({8'h00, rd_data}, {8'h00, e});
  endtask
  // Poll one status flag, giving up after a bounded number of reads.
  task automatic poll(input int b);
    int n;
    for (n = 0; n < 3000 && rd_data[b] !== 1'b1; n++) begin
      addr <= `UFB_ADDR_STATUS_A;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(posedge clock);
    end
    if (n == 3000) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Start bit, data LSB first, optional parity, then stop bits; bad flips parity.
  function automatic logic [15:0] frame(input logic [8:0] d, input int n, input logic [1:0] par,
      input int stops, input bit bad, output int len);
    logic [15:0] v;
    logic p;
    v = '0;
    p = par[0] ^ bad;
    for (int i = 0; i < n; i++) begin
      v[1 + i] = d[i];
      p ^= d[i];
    end
    len = n + 1;
    if (par[1]) begin
      v[len] = p;
      len++;
    end
    for (int i = 0; i < stops; i++) v[len + i] = 1'b1;
    len += stops;
    return v;
  endfunction
  // Two characters back to back out, then one character in, for case i.
  task automatic run_case(input int i, input int bt);
    logic [15:0] v;
    logic [15:0] got;
    int len;
    bit ok;
    wr(`UFB_ADDR_FORMAT, {2'b00, pm[i], sb[i], sz[i][1:0], 1'b0});
    wr(`UFB_ADDR_CTRL_B, {5'b00011, sz[i][2], 1'b0, dv[i][8]});
    v = frame(dv[i], nbits[i], pm[i], 1 + sb[i], 1'b0, len);
    v[len] = 1'b1; // The line rests high for one bit before the next start bit.
    fork
      u_peer.grab(len + 1, bt, got, ok);
      begin
        wr(`UFB_ADDR_DATA, dv[i][7:0]);
        @(posedge clock);
        wr(`UFB_ADDR_DATA, 8'h00);
      end
    join
    if (!ok) begin
      failures++;
      tally_and_finish();
    end
    chk(got, v);
    poll(6);
    wr(`UFB_ADDR_STATUS_A, stat_w | 8'h40);
    rc(`UFB_ADDR_STATUS_A, stat_w | 8'h20);
    v = frame(dv[i], nbits[i], pm[i], 1, bd[i], len);
    u_peer.send(v, len, bt);
    poll(7);
    rc(`UFB_ADDR_CTRL_B, {5'b00011, sz[i][2], (nbits[i] == 9) & dv[i][8], dv[i][8]});
    rc(`UFB_ADDR_STATUS_A, {5'b10100, pm[i][1] & bd[i], stat_w[1], 1'b0});
    rc(`UFB_ADDR_DATA, dv[i][7:0] & ((nbits[i] >= 8) ? 8'hFF : 8'hFF >> (8 - nbits[i])));
  endtask
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    logic [15:0] sv;
    logic [15:0] sg;
    int sl;
    bit so;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rc(`UFB_ADDR_FORMAT, 8'h06);
    rc(`UFB_ADDR_STATUS_A, 8'h20);
    rc(`UFB_ADDR_CTRL_B, 8'h00);
    wr(3'h6, 8'hFF);
    rc(3'h6, 8'h00);
    wr(`UFB_ADDR_BAUD_HI, 8'h0A);
    rc(`UFB_ADDR_BAUD_HI, 8'h0A);
    wr(`UFB_ADDR_BAUD_HI, 8'h00);
    wr(`UFB_ADDR_BAUD_LO, 8'h00);
    for (int i = 0; i < 5; i++) run_case(i, 16);
    wr(`UFB_ADDR_BAUD_LO, 8'h01);
    rc(`UFB_ADDR_BAUD_LO, 8'h01);
    run_case(3, 32);
    wr(`UFB_ADDR_BAUD_LO, 8'h00);
    stat_w = 8'h02;
    wr(`UFB_ADDR_STATUS_A, stat_w);
    run_case(4, 8);
    stat_w = 8'h00;
    wr(`UFB_ADDR_STATUS_A, stat_w);
    for (int p = 0; p < 2; p++) begin
      wr(`UFB_ADDR_FORMAT, {7'b0100011, p[0]});
      sv = frame(9'h15A, 9, 2'b00, 1, 1'b0, sl);
      fork
        u_peer.grab(sl, 2, sg, so);
        wr(`UFB_ADDR_DATA, 8'h5A);
      join
      chk({15'h0000, so}, 16'h0001);
      chk(sg, sv);
      poll(6);
      wr(`UFB_ADDR_STATUS_A, 8'h40);
      chk({15'h0000, xck_oe}, 16'h0001);
    end
    wr(`UFB_ADDR_FORMAT, 8'h06);
    @(posedge clock);
    chk({14'h0000, xck_oe, xck_o}, 16'h0000);
    tally_and_finish();
  end
endmodule
